// ---- include/bsp_pkg.sv ----
/*
  Shared constants, state encoding and lane mapping functions for the burst
  SRAM port controller. Assumes a single 250 MHz fabric clock domain.
*/
`default_nettype none

package bsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CAL_TIME_US = 100;
  localparam int unsigned CAL_CYCLES = CAL_TIME_US * CLK_MHZ;
  localparam int unsigned RD_LAT = 10;
  localparam int unsigned EXT_LAT = 2;
  localparam int unsigned SYNC_LEN = 2;
  localparam int unsigned ALIGN = RD_LAT - 1 - EXT_LAT - SYNC_LEN;
  localparam int unsigned VLEN = RD_LAT + 1;

  ////////////////////////////////////////////////////////////////////////////
  // widths and register map
  localparam int unsigned LANES = 4;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam int unsigned CTRL_WR = 0;
  localparam int unsigned CTRL_RD = 1;
  localparam int unsigned CTRL_SEL = 2;
  localparam int unsigned CTRL_MASK = 4;
  localparam int unsigned STAT_READY = 0;
  localparam int unsigned STAT_FAIL = 1;
  localparam int unsigned STAT_BUSY = 2;
  localparam int unsigned STAT_CHK = 4;
  localparam logic [3:0] RST_MASK = 4'hf;
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // calibration pattern and write sources
  localparam logic [31:0] CAL_ADDR = 32'h0;
  localparam logic [35:0] CAL_PAT0 = 36'ha5a5a5a5a;
  localparam logic [35:0] CAL_PAT1 = 36'h5a5a5a5a5;
  localparam logic [1:0] SRC_FAB = 2'h0;
  localparam logic [1:0] SRC_CPU = 2'h1;
  localparam logic [1:0] SRC_CAL = 2'h2;

  typedef enum logic [5:0] {
    ST_WAIT = 6'h01,
    ST_CAL_WR = 6'h02,
    ST_CAL_RD = 6'h04,
    ST_CAL_CHK = 6'h08,
    ST_RUN = 6'h10,
    ST_FAIL = 6'h20
  } bsp_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // fabric word (checks on 35:32) to pin word (9-bit lanes) and back
  function automatic logic [35:0] bsp_to_phys(input logic [35:0] w);
    logic [35:0] p;
    p = '0;
    for (int i = 0; i < LANES; i++) begin
      p[i*9 +: 9] = {w[32+i], w[i*8 +: 8]};
    end
    return p;
  endfunction : bsp_to_phys

  function automatic logic [35:0] bsp_from_phys(input logic [35:0] p);
    logic [35:0] w;
    w = '0;
    for (int i = 0; i < LANES; i++) begin
      w[32+i] = p[i*9+8];
      w[i*8 +: 8] = p[i*9 +: 8];
    end
    return w;
  endfunction : bsp_from_phys

endpackage : bsp_pkg

`default_nettype wire

// ---- include/bsp_cpu_if.sv ----
/*
  Carrier between the register slave and the command core: cpu access
  request, its data, and status back. Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface bsp_cpu_if;
  logic go_wr;
  logic go_rd;
  logic sel;
  logic [3:0] mask;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [35:0] rdata;
  logic busy;
  logic ready;
  logic fail;

  modport regs (
    output go_wr, go_rd, sel, mask, addr, wdata,
    input rdata, busy, ready, fail
  );

  modport core (
    input go_wr, go_rd, sel, mask, addr, wdata,
    output rdata, busy, ready, fail
  );
endinterface : bsp_cpu_if

`default_nettype wire

// ---- design/bsp_regs.sv ----
/*
  AXI4-Lite register slave for the burst SRAM port controller.
  Assumes ref_clk, synchronous active-high rst, single outstanding access.
*/
`timescale 1ns/1ps
`default_nettype none

module bsp_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  bsp_cpu_if.regs cpu
);
  import bsp_pkg::*;

  typedef struct packed {
    logic awv;
    logic [7:0] awa;
    logic wv;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic sel;
    logic [3:0] mask;
    logic [31:0] addr;
    logic [31:0] wdat;
    logic go_wr;
    logic go_rd;
  } bsp_regs_st_t;

  bsp_regs_st_t q;
  bsp_regs_st_t n;

  function automatic logic [31:0] bsp_merge(input logic [31:0] o, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : bsp_merge

  //////////////////////////////////////////////////////////////////////////////
  // write and read channels
  always_comb begin
    n = q;
    n.go_wr = 1'b0;
    n.go_rd = 1'b0;
    if (s_axi_awvalid && !q.awv) begin
      n.awv = 1'b1;
      n.awa = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !q.wv) begin
      n.wv = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end
    if (s_axi_bready && q.bv) begin
      n.bv = 1'b0;
    end
    if (q.awv && q.wv && !q.bv) begin
      n.awv = 1'b0;
      n.wv = 1'b0;
      n.bv = 1'b1;
      n.br = RESP_OKAY;
      case (q.awa)
        OFF_CTRL: begin
          if (q.ws[0]) begin
            n.go_wr = q.wd[CTRL_WR];
            n.go_rd = q.wd[CTRL_RD];
            n.sel = q.wd[CTRL_SEL];
            n.mask = q.wd[CTRL_MASK +: 4];
          end
        end
        OFF_ADDR: n.addr = bsp_merge(q.addr, q.wd, q.ws);
        OFF_WDATA: n.wdat = bsp_merge(q.wdat, q.wd, q.ws);
        OFF_RDATA, OFF_STATUS: n.br = RESP_OKAY;
        default: n.br = RESP_DECERR;
      endcase
    end
    if (s_axi_rready && q.rv) begin
      n.rv = 1'b0;
    end
    if (s_axi_arvalid && !q.rv) begin
      n.rv = 1'b1;
      n.rr = RESP_OKAY;
      n.rd = '0;
      case (s_axi_araddr[7:0])
        OFF_CTRL: begin
          n.rd[CTRL_SEL] = q.sel;
          n.rd[CTRL_MASK +: 4] = q.mask;
        end
        OFF_ADDR: n.rd = q.addr;
        OFF_WDATA: n.rd = q.wdat;
        OFF_RDATA: n.rd = cpu.rdata[31:0];
        OFF_STATUS: begin
          n.rd[STAT_READY] = cpu.ready;
          n.rd[STAT_FAIL] = cpu.fail;
          n.rd[STAT_BUSY] = cpu.busy;
          n.rd[STAT_CHK +: 4] = cpu.rdata[35:32];
        end
        default: n.rr = RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.mask <= RST_MASK;
      q.addr <= RST_WORD;
      q.wdat <= RST_WORD;
    end else begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign s_axi_awready = !q.awv;
  assign s_axi_wready = !q.wv;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.br;
  assign s_axi_arready = !q.rv;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rr;
  assign cpu.go_wr = q.go_wr;
  assign cpu.go_rd = q.go_rd;
  assign cpu.sel = q.sel;
  assign cpu.mask = q.mask;
  assign cpu.addr = q.addr;
  assign cpu.wdata = q.wdat;

endmodule : bsp_regs

`default_nettype wire

// ---- design/bsp_ctrl.sv ----
/*
  Burst SRAM port controller top: fabric command port, pin side of the
  external burst SRAM, calibration sequencer, optional cpu access port.
  Assumes one 250 MHz clock, synchronous active-high reset, and an SRAM
  that returns read words EXT_LAT cycles after the command shows on pins.
*/
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none

module bsp_ctrl #(
  parameter bit USE_CPU = 1'b1,
  parameter int unsigned CAL_CYC = bsp_pkg::CAL_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // fabric command port
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [31:0] address,
  input wire logic [3:0] lane_write_mask,
  input wire logic [35:0] wr_data,
  output logic [35:0] rd_data,
  output logic rd_valid,
  output logic ack,
  output logic phy_ready,
  output logic cal_fail,
  // sram pins
  output logic [31:0] sram_addr,
  output logic sram_rd_n,
  output logic sram_wr_n,
  output logic [35:0] sram_d,
  output logic [3:0] sram_bw_n,
  input wire logic [35:0] sram_q,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import bsp_pkg::*;

  typedef struct packed {
    bsp_state_t st;
    logic [31:0] cnt;
    logic cal_ok;
    logic rd_prev;
    logic wr_prev;
    logic [1:0] wsrc;
    logic [31:0] p_addr;
    logic p_rd_n;
    logic p_wr_n;
    logic [35:0] p_d;
    logic [3:0] p_bw_n;
    logic [35:0] s1;
    logic [35:0] s2;
    logic [ALIGN-1:0][35:0] al;
    logic [VLEN-1:0] vf;
    logic [VLEN-1:0] vc;
    logic [VLEN-1:0] vk;
    logic pend;
    logic busy;
    logic cpu_wr;
    logic [35:0] crd;
  } bsp_ctrl_st_t;

  bsp_ctrl_st_t q;
  bsp_ctrl_st_t n;

  logic cpu_go_wr;
  logic cpu_go_rd;
  logic run;
  logic rd_ok;
  logic wr_ok;
  logic f_rd;
  logic f_wr;
  logic slot;
  logic c_rd;
  logic c_wr;
  logic k_rd;
  logic k_wr;
  logic is_rd;
  logic is_wr;
  logic [1:0] src;
  logic [35:0] rd_out;
  logic [35:0] word;
  logic [3:0] mask;

  bsp_cpu_if cpu ();

  //////////////////////////////////////////////////////////////////////////////
  // register slave
  bsp_regs u_regs (
    .ref_clk(ref_clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cpu(cpu.regs)
  );

  // cpu port present only when built in
  generate
    if (USE_CPU) begin : g_cpu
      assign cpu_go_wr = cpu.go_wr;
      assign cpu_go_rd = cpu.go_rd;
    end else begin : g_nocpu
      assign cpu_go_wr = 1'b0;
      assign cpu_go_rd = 1'b0;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // command decode
  assign run = (q.st == ST_RUN);
  assign rd_ok = rd_en && !q.rd_prev;
  assign wr_ok = wr_en && !q.wr_prev;
  assign f_rd = run && rd_ok;
  assign f_wr = run && wr_ok && !rd_ok;
  assign slot = run && q.pend && !rd_en && !wr_en;
  assign c_wr = slot && q.cpu_wr && !q.wr_prev;
  assign c_rd = slot && !q.cpu_wr && !q.rd_prev;
  assign k_wr = (q.st == ST_CAL_WR);
  assign k_rd = (q.st == ST_CAL_RD);
  assign is_rd = f_rd || c_rd || k_rd;
  assign is_wr = f_wr || c_wr || k_wr;
  assign src = !is_wr ? q.wsrc : (f_wr ? SRC_FAB : (c_wr ? SRC_CPU : SRC_CAL));
  assign rd_out = q.al[ALIGN-1];

  // write word and lane mask for the first or second beat
  always_comb begin
    word = '0;
    mask = '0;
    case (src)
      SRC_FAB: begin
        word = wr_data;
        mask = lane_write_mask;
      end
      SRC_CPU: begin
        word = {4'h0, cpu.wdata};
        mask = (cpu.sel == !is_wr) ? cpu.mask : 4'h0;
      end
      default: begin
        word = is_wr ? CAL_PAT0 : CAL_PAT1;
        mask = 4'hf;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = q;
    // pin command, one burst address per command
    n.p_rd_n = !is_rd;
    n.p_wr_n = !is_wr;
    n.rd_prev = is_rd;
    n.wr_prev = is_wr;
    if (f_rd || f_wr) begin
      n.p_addr = address;
    end else if (c_rd || c_wr) begin
      n.p_addr = cpu.addr;
    end else if (k_rd || k_wr) begin
      n.p_addr = CAL_ADDR;
    end
    if (is_wr) begin
      n.wsrc = src;
    end
    // write beats, lanes mapped to 9-bit pin lanes
    n.p_d = bsp_to_phys(word);
    n.p_bw_n = (is_wr || q.wr_prev) ? ~mask : 4'hf;
    // read return: two sync stages then alignment to the fixed latency
    n.s1 = sram_q;
    n.s2 = q.s1;
    n.al[0] = bsp_from_phys(q.s2);
    for (int i = 1; i < ALIGN; i++) begin
      n.al[i] = q.al[i-1];
    end
    n.vf = {q.vf[VLEN-2:0], f_rd};
    n.vc = {q.vc[VLEN-2:0], c_rd};
    n.vk = {q.vk[VLEN-2:0], k_rd};
    // cpu access port
    if ((cpu_go_wr || cpu_go_rd) && !q.busy) begin
      n.pend = 1'b1;
      n.busy = 1'b1;
      n.cpu_wr = cpu_go_wr;
    end
    if (c_wr || c_rd) begin
      n.pend = 1'b0;
    end
    if (q.wr_prev && q.wsrc == SRC_CPU) begin
      n.busy = 1'b0;
    end
    if (q.vc[RD_LAT-1] && !cpu.sel) begin
      n.crd = rd_out;
    end
    if (q.vc[RD_LAT] && cpu.sel) begin
      n.crd = rd_out;
    end
    if (q.vc[RD_LAT]) begin
      n.busy = 1'b0;
    end
    // calibration sequence
    case (q.st)
      ST_WAIT: begin
        if (q.cnt >= CAL_CYC - 1) begin
          n.st = ST_CAL_WR;
        end else begin
          n.cnt = q.cnt + 32'h1;
        end
      end
      ST_CAL_WR: n.st = ST_CAL_RD;
      ST_CAL_RD: n.st = ST_CAL_CHK;
      ST_CAL_CHK: begin
        if (q.vk[RD_LAT-1]) begin
          n.cal_ok = (rd_out == CAL_PAT0);
        end
        if (q.vk[RD_LAT]) begin
          n.st = (q.cal_ok && rd_out == CAL_PAT1) ? ST_RUN : ST_FAIL;
        end
      end
      ST_RUN: n.st = ST_RUN;
      ST_FAIL: n.st = ST_FAIL;
      default: n.st = ST_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.st <= ST_WAIT;
      q.p_rd_n <= 1'b1;
      q.p_wr_n <= 1'b1;
      q.p_bw_n <= 4'hf;
    end else begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rd_data = rd_out;
  assign rd_valid = q.vf[RD_LAT-1] || q.vf[RD_LAT];
  assign ack = !q.busy;
  assign phy_ready = (q.st == ST_RUN);
  assign cal_fail = (q.st == ST_FAIL);
  assign sram_addr = q.p_addr;
  assign sram_rd_n = q.p_rd_n;
  assign sram_wr_n = q.p_wr_n;
  assign sram_d = q.p_d;
  assign sram_bw_n = q.p_bw_n;
  assign cpu.rdata = q.crd;
  assign cpu.busy = q.busy;
  assign cpu.ready = phy_ready;
  assign cpu.fail = cal_fail;

endmodule : bsp_ctrl

`default_nettype wire

// ---- dv/bsp_sram_model.sv ----
/*
  Pin-level model of the external burst sram: 9-bit lanes, active-low lane writes.
  Assumes word0 is due on sram_q two cycles after the read command shows on the pins.
*/
`timescale 1ns/1ps
`default_nettype none

module bsp_sram_model (
  // clock
  input wire logic ref_clk,
  // sram pins
  input wire logic [31:0] sram_addr,
  input wire logic sram_rd_n,
  input wire logic sram_wr_n,
  input wire logic [35:0] sram_d,
  input wire logic [3:0] sram_bw_n,
  output logic [35:0] sram_q
);
  logic [35:0] mem [logic [32:0]];
  logic [31:0] wa = '0;
  logic [31:0] ra = '0;
  logic wp = 1'b0;
  logic [1:0] rp = 2'h0;

  initial sram_q = 36'h0;

  function automatic logic [35:0] get(input logic [32:0] k);
    return mem.exists(k) ? mem[k] : 36'h0;
  endfunction : get

  task automatic put(input logic [32:0] k);
    logic [35:0] v;
    v = get(k);
    for (int i = 0; i < 4; i++) if (!sram_bw_n[i]) v[i*9 +: 9] = sram_d[i*9 +: 9];
    mem[k] = v;
  endtask : put

  ////////////////////////////////////////////////////////////////////////////
  // two-word bursts; released output toggles every cycle
  always @(posedge ref_clk) begin
    if (wp) put({wa, 1'b1});
    if (!sram_wr_n) put({sram_addr, 1'b0});
    wp <= !sram_wr_n;
    wa <= sram_addr;
    if (!sram_rd_n) ra <= sram_addr;
    rp <= {rp[0], !sram_rd_n};
    if (rp[0]) sram_q <= get({ra, 1'b0});
    else if (rp[1]) sram_q <= get({ra, 1'b1});
    else sram_q <= ~sram_q;
  end
endmodule : bsp_sram_model

`default_nettype wire

// ---- dv/bsp_ctrl_chk.sv ----
/*
  Assertions on the fabric port and sram pins of bsp_ctrl.
  Assumes one clock, synchronous active-high reset; bound to every bsp_ctrl.
*/
`timescale 1ns/1ps
`default_nettype none

module bsp_ctrl_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // fabric port
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [31:0] address,
  input wire logic [3:0] lane_write_mask,
  input wire logic rd_valid,
  input wire logic phy_ready,
  input wire logic cal_fail,
  // sram pins
  input wire logic [31:0] sram_addr,
  input wire logic sram_rd_n,
  input wire logic sram_wr_n,
  input wire logic [3:0] sram_bw_n
);
  logic rd_tk, wr_tk, rd_tk_r, wr_tk_r;

  assign rd_tk = rd_en && phy_ready && !rd_tk_r;
  assign wr_tk = wr_en && phy_ready && !wr_tk_r && !rd_tk;

  always_ff @(posedge ref_clk) begin
    rd_tk_r <= rst ? 1'b0 : rd_tk;
    wr_tk_r <= rst ? 1'b0 : wr_tk;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence rd_burst;
    rd_valid [*2];
  endsequence
  sequence wr_beat;
    !sram_wr_n && sram_bw_n == ~$past(lane_write_mask) && sram_addr == $past(address);
  endsequence

  rd_lat_a: assert property (rd_tk |-> ##10 rd_burst)
    else $error("read data not returned on time");
  rd_pin_a: assert property (rd_tk |=> !sram_rd_n && sram_addr == $past(address))
    else $error("read not issued on pins");
  rd_rep_a: assert property (rd_tk ##1 rd_en |=> sram_rd_n)
    else $error("repeated read not ignored");
  both_rd_a: assert property (rd_en && wr_en && phy_ready && !rd_tk_r |=> !sram_rd_n && sram_wr_n)
    else $error("read did not win over write");
  both_wr_a: assert property (rd_en && wr_en && rd_tk_r && !wr_tk_r |=> !sram_wr_n && sram_rd_n)
    else $error("write did not win after read");
  wr_mask_a: assert property (wr_tk |=> wr_beat ##1 (sram_wr_n && sram_bw_n == ~$past(lane_write_mask)))
    else $error("write burst or lane mask wrong");
  rv_only_a: assert property (rd_valid |-> $past(rd_tk, 10) || $past(rd_tk, 11))
    else $error("read valid outside a burst");
  cal_ok_a: assert property (phy_ready |=> phy_ready && !cal_fail)
    else $error("calibration status unstable");
endmodule : bsp_ctrl_chk

bind bsp_ctrl bsp_ctrl_chk chk_i (.ref_clk, .rst, .rd_en, .wr_en, .address, .lane_write_mask, .rd_valid,
  .phy_ready, .cal_fail, .sram_addr, .sram_rd_n, .sram_wr_n, .sram_bw_n);

`default_nettype wire

// ---- dv/bsp_ctrl_tb_top.sv ----
/*
  Self-checking bench: fabric bursts, arbitration, cpu port over axi4-lite.
  Assumes bsp_pkg, bsp_cpu_if, design sources and dv models compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module bsp_ctrl_tb_top;
  import bsp_pkg::*;
  logic ref_clk = 0, rst = 1, rd_en = 0, wr_en = 0;
  logic [31:0] address = '0, sram_addr, s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] lane_write_mask = '0, sram_bw_n, s_axi_wstrb = 4'hf;
  logic [35:0] wr_data = '0, rd_data, sram_d, sram_q;
  logic rd_valid, ack, phy_ready, cal_fail, sram_rd_n, sram_wr_n;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail = 0, checks = 0;
  logic [31:0] seed = 32'h296a7069, pa;
  logic [35:0] model [logic [32:0]];
  logic [35:0] expq [$];
  bit prt, pwt, pw;

  bsp_ctrl #(.USE_CPU(1'b1), .CAL_CYC(20)) dut (.ref_clk, .rst, .rd_en, .wr_en, .address, .lane_write_mask,
    .wr_data, .rd_data, .rd_valid, .ack, .phy_ready, .cal_fail, .sram_addr, .sram_rd_n, .sram_wr_n, .sram_d,
    .sram_bw_n, .sram_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  bsp_sram_model mem_i (.ref_clk, .sram_addr, .sram_rd_n, .sram_wr_n, .sram_d, .sram_bw_n, .sram_q);

  initial forever #2 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [35:0] get(input logic [32:0] k);
    return model.exists(k) ? model[k] : 36'h0;
  endfunction : get

  task automatic upd(input logic [32:0] k, input logic [3:0] m, input logic [35:0] d);
    logic [35:0] v;
    v = get(k);
    for (int i = 0; i < 4; i++) if (m[i]) begin
      v[i*8 +: 8] = d[i*8 +: 8];
      v[32+i] = d[32+i];
    end
    model[k] = v;
  endtask : upd

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic finish_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic tmo();
    n_fail++;
    $display("[FAIL] t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1);
    finish_test();
  endtask : tmo

  // one fabric cycle; the bench model follows what is taken
  task automatic step(input bit r, input bit w, input logic [31:0] a, input logic [3:0] m, input logic [35:0] d);
    bit rt, wt;
    rt = r && !prt;
    wt = w && !pwt && !rt;
    @(posedge ref_clk);
    rd_en <= r;
    wr_en <= w;
    address <= a;
    lane_write_mask <= m;
    wr_data <= d;
    if (pw) upd({pa, 1'b1}, m, d);
    if (wt) upd({a, 1'b0}, m, d);
    if (rt) begin
      expq.push_back(get({a, 1'b0}));
      expq.push_back(get({a, 1'b1}));
    end
    prt = rt;
    pwt = wt;
    pw = wt;
    pa = a;
  endtask : step

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r, output logic ak);
    bit ha, hw, hb;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      ak = ack;
      @(posedge ref_clk);
      if (ha) s_axi_awvalid <= 0;
      if (hw) s_axi_wvalid <= 0;
      if (hb) begin
        s_axi_bready <= 0;
        return;
      end
    end
    tmo();
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ha, hv;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      ha = s_axi_arvalid && s_axi_arready;
      hv = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ha) s_axi_arvalid <= 0;
      if (hv) begin
        s_axi_rready <= 0;
        return;
      end
    end
    tmo();
  endtask : axi_rd

  task automatic wait_ack();
    for (int n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      if (ack === 1'b1) return;
    end
    tmo();
  endtask : wait_ack

  task automatic drain(input string name);
    repeat (14) @(negedge ref_clk);
    cmp(expq.size(), 0);
    $display("test %s done", name);
  endtask : drain

  always @(negedge ref_clk) begin
    if (!rst && rd_valid === 1'b1) cmp(rd_data, expq.size() ? expq.pop_front() : 36'hx);
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [35:0] d1;
    logic [31:0] rv;
    logic [1:0] rsp;
    logic ak;
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    @(negedge ref_clk);
    cmp(ack, 1);
    for (int n = 0; n < 300 && phy_ready !== 1'b1; n++) @(negedge ref_clk);
    cmp(phy_ready, 1);
    cmp(cal_fail, 0);
    $display("test calibration done");
    for (int i = 0; i < 16; i++) step(0, 1, 32'h100 + i / 2, 4'(xs()), {xs(), 4'h0} ^ 36'(xs()));
    for (int i = 0; i < 16; i++) step(1, 0, 32'h100 + i / 2, 4'h0, 36'h0);
    step(0, 0, 0, 4'h0, 36'h0);
    drain("bursts");
    step(1, 1, 32'h101, 4'hf, 36'h0);
    step(1, 1, 32'h180, 4'hf, 36'h123456789);
    step(0, 0, 0, 4'hf, 36'h987654321);
    step(1, 0, 32'h180, 4'h0, 36'h0);
    step(0, 0, 0, 4'h0, 36'h0);
    step(1, 0, 32'h101, 4'h0, 36'h0);
    step(0, 0, 0, 4'h0, 36'h0);
    drain("arbitration");
    step(0, 1, 32'h40, 4'hf, 36'hfffffffff);
    step(0, 0, 0, 4'hf, 36'hf0f0f0f0f);
    axi_wr(OFF_ADDR, 32'h40, rsp, ak);
    axi_wr(OFF_WDATA, 32'hc3c3c3c3, rsp, ak);
    axi_wr(OFF_CTRL, 32'h51, rsp, ak);
    cmp(rsp, RESP_OKAY);
    cmp(ak, 1);
    @(negedge ref_clk);
    cmp(ack, 0);
    wait_ack();
    upd({32'h40, 1'b0}, 4'h5, {4'h0, 32'hc3c3c3c3});
    axi_wr(OFF_CTRL, 32'h6, rsp, ak);
    wait_ack();
    d1 = get({32'h40, 1'b1});
    axi_rd(OFF_RDATA, rv, rsp);
    cmp(rv, d1[31:0]);
    axi_rd(OFF_STATUS, rv, rsp);
    cmp(rv[7:4], d1[35:32]);
    cmp(rv[0], 1);
    axi_rd(32'h20, rv, rsp);
    cmp(rsp, RESP_DECERR);
    cmp(rv, 0);
    step(1, 0, 32'h40, 4'h0, 36'h0);
    step(0, 0, 0, 4'h0, 36'h0);
    drain("cpu port");
    finish_test();
  end
endmodule : bsp_ctrl_tb_top

`default_nettype wire
